// *** include/bsew_pkg.sv ***
// constants and types of the bit-serial eeprom page write controller
`default_nettype none
package bsew_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_LOW_NS = 50;
  localparam int T_HIGH_NS = 50;
  localparam int T_LOW_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int PAGE_BYTES = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] LOW_LOAD = CNT_W'(T_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_LOAD = CNT_W'(T_HIGH_CYC - 1);
  localparam logic [3:0] ADDR_LAST = 4'(ADDR_BITS - 1);
  localparam logic [3:0] BYTE_LAST = 4'(BYTE_BITS - 1);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RR1 = 4'h1,
    S_RW0 = 4'h2,
    S_RR2 = 4'h3,
    S_ADDR = 4'h4,
    S_DATA = 4'h5,
    S_GR1 = 4'h6,
    S_GW1 = 4'h7,
    S_GR2 = 4'h8,
    S_POLL = 4'h9,
    S_DONE = 4'hA
  } bsew_state_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_SETUP = 3'h1,
    C_LOW = 3'h2,
    C_HOLD = 3'h3,
    C_HIGH = 3'h4
  } bsew_cyc_t;
endpackage
`default_nettype wire

// *** hdl/bsew_fifo.sv ***
// page data fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module bsew_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [WIDTH-1:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [WIDTH-1:0] rdData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [CW-1:0] count_r;
  logic room_r;
  logic empty_r;
  wire push = wrValid && room_r;
  wire pop = rdReady && !empty_r;
  wire [CW-1:0] count_nxt = count_r + CW'(push) - CW'(pop);

  assign wrReady = room_r;
  assign rdValid = !empty_r;
  assign rdData = mem[rdPtr_r];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_r] <= wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      room_r <= 1'b1;
      empty_r <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + PW'(1);
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + PW'(1);
      end
      count_r <= count_nxt;
      room_r <= (count_nxt != FULL_CNT);
      empty_r <= (count_nxt == '0);
    end
  end
endmodule
`default_nettype wire

// *** hdl/bsew_host.sv ***
// host controller that page-writes a bit-serial eeprom through its bus pins
//
// How it works
// - reset, address, data bytes, start command, in order
// - sixteen address writes, msb first, no reads
// - data as whole bytes of eight writes
// - read ends load; write one, read starts programming
// - never write strobe and output enable low together
`timescale 1ns/100ps
`default_nettype none
module bsew_host
  import bsew_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [ADDR_BITS-1:0] cmdAddr,
  input wire logic [4:0] cmdLenM1,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [BYTE_BITS-1:0] wrData,
  input wire logic writeProtect,
  output logic busy,
  output logic done,
  output logic ceN,
  output logic oeN,
  output logic weN,
  output logic wpN,
  output logic ioOut,
  output logic ioOe,
  input wire logic ioIn
);
  bsew_state_t state_r;
  bsew_state_t state_nxt;
  bsew_cyc_t cyc_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0] bitCnt_r;
  logic [4:0] byteLeft_r;
  logic [ADDR_BITS-1:0] shift_r;
  logic loaded_r;
  logic cycRead_r;
  logic rdBit_r;
  logic cmdReady_r;
  logic busy_r;
  logic done_r;
  logic ceN_r;
  logic oeN_r;
  logic weN_r;
  logic wpN_r;
  logic ioOut_r;
  logic ioOe_r;
  logic fifoValid;
  logic [BYTE_BITS-1:0] fifoData;

  wire accept = cmdValid && cmdReady_r && (state_r == S_IDLE);
  wire stepRead = (state_r == S_RR1) || (state_r == S_RR2) || (state_r == S_GR1) ||
                  (state_r == S_GR2) || (state_r == S_POLL);
  wire stepBit = (state_r == S_GW1) ? 1'b1 : (state_r == S_RW0) ? 1'b0 : shift_r[ADDR_BITS-1];
  wire active = (state_r != S_IDLE) && (state_r != S_DONE);
  wire needCycle = active && ((state_r != S_DATA) || loaded_r);
  wire cycStart = (cyc_r == C_IDLE) && needCycle;
  wire lowEnd = (cyc_r == C_LOW) && (cnt_r == '0);
  wire cycDone = (cyc_r == C_HIGH) && (cnt_r == '0);
  wire fifoPop = (state_r == S_DATA) && !loaded_r && (cyc_r == C_IDLE) && fifoValid;
  wire addrLast = (state_r == S_ADDR) && (bitCnt_r == ADDR_LAST);
  wire byteLast = (state_r == S_DATA) && (bitCnt_r == BYTE_LAST);

  // fifo stalls the sequencer between bytes; chip select stays high meanwhile
  bsew_fifo #(
    .WIDTH(BYTE_BITS),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .wrValid(wrValid),
    .wrReady(wrReady),
    .wrData(wrData),
    .rdValid(fifoValid),
    .rdReady(fifoPop),
    .rdData(fifoData)
  );

  // step order of one page write
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: if (accept) state_nxt = S_RR1;
      S_RR1: if (cycDone) state_nxt = S_RW0;
      S_RW0: if (cycDone) state_nxt = S_RR2;
      S_RR2: if (cycDone) state_nxt = S_ADDR;
      S_ADDR: if (cycDone && addrLast) state_nxt = S_DATA;
      S_DATA: if (cycDone && byteLast && (byteLeft_r == '0)) state_nxt = S_GR1;
      S_GR1: if (cycDone) state_nxt = S_GW1;
      S_GW1: if (cycDone) state_nxt = S_GR2;
      S_GR2: if (cycDone) state_nxt = S_POLL;
      S_POLL: if (cycDone && rdBit_r) state_nxt = S_DONE;
      S_DONE: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      cmdReady_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      wpN_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmdReady_r <= (state_nxt == S_IDLE);
      busy_r <= (state_nxt != S_IDLE);
      done_r <= (state_nxt == S_DONE);
      wpN_r <= !writeProtect;
    end
  end

  // address and data shifter, byte and bit counters
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= '0;
      bitCnt_r <= '0;
      byteLeft_r <= '0;
      loaded_r <= 1'b0;
    end else if (accept) begin
      shift_r <= cmdAddr;
      bitCnt_r <= '0;
      byteLeft_r <= cmdLenM1;
      loaded_r <= 1'b0;
    end else if (fifoPop) begin
      shift_r <= {fifoData, {(ADDR_BITS-BYTE_BITS){1'b0}}};
      loaded_r <= 1'b1;
    end else if (cycDone && ((state_r == S_ADDR) || (state_r == S_DATA))) begin
      shift_r <= {shift_r[ADDR_BITS-2:0], 1'b0};
      bitCnt_r <= (addrLast || byteLast) ? '0 : bitCnt_r + 4'h1;
      if (byteLast) begin
        loaded_r <= 1'b0;
        byteLeft_r <= byteLeft_r - 5'h01;
      end
    end
  end

  // one bus cycle: setup, strobe low, hold, recovery
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_r <= C_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (cyc_r)
        C_IDLE: if (cycStart) cyc_r <= C_SETUP;
        C_SETUP: begin
          cyc_r <= C_LOW;
          cnt_r <= LOW_LOAD;
        end
        C_LOW: begin
          if (cnt_r == '0) begin
            cyc_r <= C_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        C_HOLD: begin
          cyc_r <= C_HIGH;
          cnt_r <= HIGH_LOAD;
        end
        C_HIGH: begin
          if (cnt_r == '0) begin
            cyc_r <= C_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: cyc_r <= C_IDLE;
      endcase
    end
  end

  // pin drivers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ceN_r <= 1'b1;
      oeN_r <= 1'b1;
      weN_r <= 1'b1;
      ioOut_r <= 1'b0;
      ioOe_r <= 1'b0;
      cycRead_r <= 1'b0;
      rdBit_r <= 1'b0;
    end else begin
      if (cycStart) begin
        cycRead_r <= stepRead;
        ioOut_r <= stepBit;
        ioOe_r <= !stepRead;
      end
      if (cyc_r == C_SETUP) begin
        ceN_r <= 1'b0;
        weN_r <= cycRead_r;
        oeN_r <= !cycRead_r;
      end
      if (lowEnd) begin
        ceN_r <= 1'b1;
        weN_r <= 1'b1;
        oeN_r <= 1'b1;
        if (cycRead_r) begin
          rdBit_r <= ioIn;
        end
      end
      if (cyc_r == C_HOLD) begin
        ioOe_r <= 1'b0;
      end
    end
  end

  assign cmdReady = cmdReady_r;
  assign busy = busy_r;
  assign done = done_r;
  assign ceN = ceN_r;
  assign oeN = oeN_r;
  assign weN = weN_r;
  assign wpN = wpN_r;
  assign ioOut = ioOut_r;
  assign ioOe = ioOe_r;
endmodule
`default_nettype wire

// *** bench/bsew_host_sva.sv ***
// port assertions of the eeprom page write host
`timescale 1ns/100ps
`default_nettype none
module bsew_host_sva (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic writeProtect,
  input wire logic busy,
  input wire logic done,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic wpN,
  input wire logic ioOut,
  input wire logic ioOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  a_strobe_overlap: assert property (weN || oeN)
    else $error("strobes overlap");
  a_select_width: assert property ($fell(ceN) |-> ##12 !ceN ##1 ceN)
    else $error("select width");
  a_write_drive: assert property (!weN |-> ioOe && !ceN)
    else $error("write undriven");
  a_read_release: assert property (!oeN |-> !ioOe && !ceN)
    else $error("read driven");
  a_data_hold: assert property ($rose(weN) |-> ioOe && $stable(ioOut))
    else $error("data not held");
  a_cmd_take: assert property (cmdValid && cmdReady |=> busy && !cmdReady)
    else $error("command lost");
  a_done_pulse: assert property (done |-> busy ##1 !done)
    else $error("done pulse");
  a_wp_follow: assert property ($past(reset_n) |-> wpN == !$past(writeProtect))
    else $error("protect pin");
  a_idle_quiet: assert property (!busy |-> ceN && weN && oeN)
    else $error("idle bus cycle");
endmodule
bind bsew_host bsew_host_sva u_sva (.sys_clk, .reset_n, .cmdValid, .cmdReady, .writeProtect, .busy,
  .done, .ceN, .oeN, .weN, .wpN, .ioOut, .ioOe);
`default_nettype wire

// *** bench/bsew_dev_model.sv ***
// behavioural model of the bit-serial eeprom pins
`timescale 1ns/100ps
`default_nettype none
module bsew_dev_model #(
  parameter int PROG_CYC = 200
) (
  input wire logic sys_clk,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic wpN,
  input wire logic ioOut,
  output logic devEn,
  output logic devOut
);
  logic [7:0] mem [0:65535];
  logic [7:0] pg [0:31];
  logic [31:0] pgMask = '0;
  logic [15:0] addr = '0;
  logic [15:0] sr = '0;
  logic [1:0] h1 = '0;
  logic [1:0] op;
  logic [4:0] pgIdx;
  logic wel = 1'b0;
  logic ceLast = 1'b1;
  logic weLast = 1'b1;
  int ph = 0;
  int nb = 0;
  int tmr = 0;
  int nProg = 0;
  assign devEn = !ceN && !oeN;
  assign devOut = tmr == 0;
  assign op = weLast ? 2'h1 : {1'b1, ioOut};
  assign pgIdx = addr[4:0] + 5'((nb - 16) >> 3);
  always @(posedge sys_clk) begin
    ceLast <= ceN;
    weLast <= weN;
    if (tmr > 0) tmr <= tmr - 1;
    if (tmr == 1 || !wpN) wel <= 1'b0;
    if (!ceLast && ceN) begin
      h1 <= op;
      // a zero address msb right after the reset read is address, not a new reset
      if (op == 2'h2 && h1 == 2'h1 && tmr == 0 && !(ph == 1 && nb == 0)) begin
        ph <= 1;
        nb <= 0;
        pgMask <= '0;
        wel <= wpN;
      end else if (ph == 1 && op != 2'h1) begin
        sr <= {sr[14:0], op[0]};
        nb <= nb + 1;
        if (nb == 15) addr <= {sr[14:0], op[0]};
        if (nb > 15 && nb % 8 == 7) begin
          pg[pgIdx] <= {sr[6:0], op[0]};
          pgMask[pgIdx] <= 1'b1;
        end
      end else if (ph == 1 && nb > 0) begin
        ph <= (nb >= 24 && nb % 8 == 0) ? 2 : 0;
      end else if (ph == 2) begin
        ph <= op == 2'h3 ? 3 : 0;
      end else if (ph == 3) begin
        ph <= 0;
        if (op == 2'h1 && wel && wpN) begin
          tmr <= PROG_CYC;
          nProg <= nProg + 1;
          for (int i = 0; i < 32; i++)
            if (pgMask[i]) mem[{addr[15:5], 5'(i)}] <= pg[i];
        end else wel <= 1'b0;
      end else if (h1 == 2'h1 && op == 2'h3) begin
        ph <= 0;
        wel <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the eeprom page write host
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  logic sys_clk = 1'b0, reset_n = 1'b0, cmdValid = 1'b0, wrValid = 1'b0, writeProtect = 1'b0, ioLast = 1'b0;
  logic [15:0] cmdAddr = '0;
  logic [4:0] cmdLenM1 = '0;
  logic [7:0] wrData = '0;
  logic cmdReady, wrReady, busy, done, ceN, oeN, weN, wpN, ioOut, ioOe, ioIn, devEn, devOut;
  int n_fail = 0;
  int checks = 0;
  assign ioIn = ioOe ? ioOut : devEn ? devOut : ~ioLast;
  always @(posedge sys_clk) ioLast <= ioIn;
  initial forever #2 sys_clk = ~sys_clk;
  bsew_host uut (.sys_clk, .reset_n, .cmdValid, .cmdReady, .cmdAddr, .cmdLenM1, .wrValid, .wrReady,
    .wrData, .writeProtect, .busy, .done, .ceN, .oeN, .weN, .wpN, .ioOut, .ioOe, .ioIn);
  bsew_dev_model dev (.sys_clk, .ceN, .oeN, .weN, .wpN, .ioOut, .devEn, .devOut);
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic hang(input int i);
    if (i < 20000) return;
    n_fail++;
    summarize();
  endtask
  task automatic push(input logic [7:0] b);
    int i;
    wrValid <= 1'b1;
    wrData <= b;
    for (i = 0; i < 20000; i++) begin
      @(posedge sys_clk);
      if (wrReady === 1'b1) break;
    end
    hang(i);
  endtask
  task automatic page(input logic [15:0] a, input int n, input int first, input logic [7:0] base);
    int i;
    int j;
    fork
      begin
        cmdValid <= 1'b1;
        cmdAddr <= a;
        cmdLenM1 <= 5'(n - 1);
        for (i = 0; i < 20000; i++) begin
          @(posedge sys_clk);
          if (cmdReady === 1'b1) break;
        end
        hang(i);
        cmdValid <= 1'b0;
        for (i = 0; i < 20000 && done !== 1'b1; i++) @(posedge sys_clk);
        hang(i);
        `CHK("busy", 1'b1, busy)
      end
      begin
        for (j = first; j < n; j++) push(base + 8'(j));
        wrValid <= 1'b0;
      end
    join
    repeat (2) @(posedge sys_clk);
    `CHK("busy", 1'b0, busy)
    `CHK("ready", 1'b1, cmdReady)
  endtask
  task automatic t_short;
    int p;
    p = dev.nProg;
    page(16'h1234, 3, 0, 8'hA0);
    for (int i = 0; i < 3; i++) `CHK("byte", 8'hA0 + 8'(i), dev.mem[16'h1234 + 16'(i)])
    `CHK("programs", p + 1, dev.nProg)
    $display("t_short ended");
  endtask
  task automatic t_wrap;
    for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
    wrValid <= 1'b0;
    @(posedge sys_clk);
    `CHK("fifo full", 1'b0, wrReady)
    page(16'h0045, 32, 8, 8'h10);
    for (int i = 0; i < 32; i++) `CHK("wrap", 8'h10 + 8'(i), dev.mem[16'h0040 + 16'((5 + i) % 32)])
    $display("t_wrap ended");
  endtask
  task automatic t_prot;
    int p;
    p = dev.nProg;
    writeProtect <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("wp pin", 1'b0, wpN)
    page(16'h1234, 1, 0, 8'h55);
    `CHK("kept", 8'hA0, dev.mem[16'h1234])
    `CHK("programs", p, dev.nProg)
    writeProtect <= 1'b0;
    $display("t_prot ended");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_short();
    t_wrap();
    t_prot();
    summarize();
  end
endmodule
`default_nettype wire
